/* rtl/shbh_pkg.sv */
// Purpose: Shared constants for the synchronous host bus handshake block
// Assumes: Host bus pins are synchronous to the host bus clock
// Notes: Address lines are the halfword lines A15-A1, held at index A(n)-1
`default_nettype none

package shbh_pkg;

  // ---------------------------------------------------------------
  // Widths and address decode
  // ---------------------------------------------------------------
  localparam int SHBH_ADDR_W = 15;         // Address lines A15-A1
  localparam int SHBH_DEC_LSB = 3;         // A4 sits at index 3
  localparam int SHBH_DEC_W = SHBH_ADDR_W - SHBH_DEC_LSB;
  localparam logic [SHBH_DEC_W-1:0] SHBH_BASE_RST = 12'h030;  // Default decode base

  // ---------------------------------------------------------------
  // Bus clock limit and core clock rate
  // ---------------------------------------------------------------
  localparam int SHBH_BUS_CLK_MAX_MHZ = 50;  // Fastest host bus clock
  localparam int SHBH_CLK_MHZ = 10;          // Core clock rate

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic SHBH_SRDY_RST = 1'b1;      // Ready output idles high
  localparam logic SHBH_MODE_RST = 1'b0;      // Synchronous mode until strap taken
  localparam logic SHBH_TGL_RST = 1'b0;       // Handshake toggles
  localparam logic [SHBH_ADDR_W-1:0] SHBH_ADDR_RST = 15'h0000;

  // Bus side handshake states
  typedef enum logic [2:0] {
    SHBH_B_IDLE,
    SHBH_B_CMD,
    SHBH_B_CORE,
    SHBH_B_READY
  } shbh_bstate_t;

endpackage

`default_nettype wire

/* rtl/shbh_sync_host_bus_handshake.sv */
// Purpose: Ready handshake of the synchronous host bus port
// Assumes: Host pins change on the host bus clock; core logic on clk_i answers requests
// Notes: Bus side runs on bus_clk_i; requests and answers cross by toggle handshake
`default_nettype none

// Behaviour
// RL1 - Host returns ready to end synchronous reads
// RL2 - Unused ready return held asserted by system
// RL3 - Host ready return low inserts burst waits
// RL4 - Host bus clock at most 50MHz
// RL5 - Bus clock low in asynchronous mode
// RL6 - Data select reaches queue data unconditionally
// RL7 - Device extends synchronous accesses with ready
// RL8 - Falling ready edge marks access ready
// RL9 - Ready output changes only on bus clock
// RL10 - Ready held low for burst waits
// RL11 - Strap selects synchronous or burst mode
// RL12 - Command cycle marks command or direction
// RL13 - Write/read high for write, low read
// RL14 - Address latched on strobe rising edge
// RL15 - Host inputs sampled on bus clock rising edges
module shbh_sync_host_bus_handshake
  import shbh_pkg::*;
#(
  parameter int ADDR_W = SHBH_ADDR_W,
  parameter logic [SHBH_DEC_W-1:0] BASE_HI = SHBH_BASE_RST
) (
  // Core clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host bus clock and strap
  input wire logic bus_clk_i,
  input wire logic bus_mode_strap_i,
  // Host bus pins, synchronous to the bus clock
  input wire logic address_strobe_n_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic address_qualifier_n_i,
  input wire logic data_path_select_n_i,
  input wire logic command_cycle_n_i,
  input wire logic sync_write_not_read_i,
  input wire logic ready_return_n_i,
  output logic sync_ready_n_o,
  // Core side access request
  output logic acc_valid_o,
  output logic [ADDR_W-1:0] acc_addr_o,
  output logic acc_write_o,
  output logic acc_data_sel_o,
  input wire logic acc_done_i,
  // Mode seen by the core
  output logic burst_mode_o
);

  // ---------------------------------------------------------------
  // Core domain: strap capture
  // ---------------------------------------------------------------
  logic strap_s1_r;
  logic strap_s2_r;
  logic strap_taken_r;
  logic mode_r;

  // Strap synchroniser, unreset so it already holds the strap at release
  always_ff @(posedge clk_i) begin
    strap_s1_r <= bus_mode_strap_i;
    strap_s2_r <= strap_s1_r;
  end

  // Mode taken once after reset release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_taken_r <= 1'b0;
      mode_r <= SHBH_MODE_RST;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      mode_r <= strap_s2_r;  // High selects burst, low synchronous [RL11]
    end
  end

  assign burst_mode_o = mode_r;

  // ---------------------------------------------------------------
  // Bus domain: crossings in
  // ---------------------------------------------------------------
  logic bmode_s1_r;
  logic bmode_s2_r;
  logic ack_tgl_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_seen_r;
  logic ack_evt;

  // Mode level into bus domain
  always_ff @(posedge bus_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bmode_s1_r <= SHBH_MODE_RST;
      bmode_s2_r <= SHBH_MODE_RST;
    end else begin
      bmode_s1_r <= mode_r;
      bmode_s2_r <= bmode_s1_r;
    end
  end

  // Answer toggle into bus domain
  always_ff @(posedge bus_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1_r <= SHBH_TGL_RST;
      ack_s2_r <= SHBH_TGL_RST;
      ack_seen_r <= SHBH_TGL_RST;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_seen_r <= ack_s2_r;
    end
  end

  assign ack_evt = ack_s2_r ^ ack_seen_r;

  // ---------------------------------------------------------------
  // Bus domain: pin sampling
  // ---------------------------------------------------------------
  logic ads_s_r;
  logic ads_prev_r;
  logic [ADDR_W-1:0] addr_s_r;
  logic qual_s_r;
  logic dps_s_r;
  logic cyc_s_r;
  logic swr_s_r;
  logic rdy_s_r;
  logic ads_rise;

  // Host pins taken on each rising bus clock edge
  always_ff @(posedge bus_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ads_s_r <= 1'b1;
      ads_prev_r <= 1'b1;
      addr_s_r <= SHBH_ADDR_RST;
      qual_s_r <= 1'b1;
      dps_s_r <= 1'b1;
      cyc_s_r <= 1'b1;
      swr_s_r <= 1'b0;
      rdy_s_r <= 1'b0;
    end else begin
      ads_s_r <= address_strobe_n_i;      // [RL15]
      ads_prev_r <= ads_s_r;
      addr_s_r <= address_i;              // [RL15]
      qual_s_r <= address_qualifier_n_i;
      dps_s_r <= data_path_select_n_i;
      cyc_s_r <= command_cycle_n_i;       // [RL15]
      swr_s_r <= sync_write_not_read_i;   // [RL15]
      rdy_s_r <= ready_return_n_i;        // [RL15]
    end
  end

  // Strobe released marks the latching moment
  assign ads_rise = ads_s_r & ~ads_prev_r;

  // ---------------------------------------------------------------
  // Bus domain: address latch and decode
  // ---------------------------------------------------------------
  shbh_bstate_t bstate_r;
  logic [ADDR_W-1:0] lat_addr_r;
  logic lat_sel_r;
  logic lat_write_r;
  logic addr_hit;
  logic sel_hit;

  // Data select bypasses qualifier and address decode
  assign sel_hit = ~dps_s_r;  // [RL6]
  assign addr_hit = ~qual_s_r & (addr_s_r[ADDR_W-1:SHBH_DEC_LSB] == BASE_HI);

  // Address and data select latched at strobe rising edge
  always_ff @(posedge bus_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_addr_r <= SHBH_ADDR_RST;
      lat_sel_r <= 1'b0;
    end else if (bstate_r == SHBH_B_IDLE && ads_rise) begin
      lat_addr_r <= addr_s_r;  // [RL14]
      lat_sel_r <= sel_hit;    // [RL6]
    end
  end

  // ---------------------------------------------------------------
  // Bus domain: handshake state machine
  // ---------------------------------------------------------------
  shbh_bstate_t bstate_nxt;
  logic srdy_r;
  logic srdy_nxt;
  logic req_tgl_r;
  logic req_fire;
  logic write_nxt;

  // Next state, ready level and request launch
  always_comb begin
    bstate_nxt = bstate_r;
    srdy_nxt = srdy_r;
    req_fire = 1'b0;
    write_nxt = lat_write_r;
    case (bstate_r)
      SHBH_B_IDLE: begin
        srdy_nxt = 1'b1;
        if (ads_rise && (sel_hit || addr_hit)) begin
          if (bmode_s2_r) begin
            write_nxt = ~cyc_s_r;   // Burst: low write, high read [RL12]
            req_fire = 1'b1;
            bstate_nxt = SHBH_B_CORE;
            srdy_nxt = 1'b0;        // Wait states while core works [RL10]
          end else begin
            bstate_nxt = SHBH_B_CMD;
          end
        end
      end
      SHBH_B_CMD: begin
        if (!cyc_s_r) begin       // Command cycle follows addressing [RL12]
          write_nxt = swr_s_r;    // High write, low read [RL13]
          req_fire = 1'b1;
          bstate_nxt = SHBH_B_CORE;
        end
      end
      SHBH_B_CORE: begin
        srdy_nxt = ~bmode_s2_r;   // Access extended until answer [RL7]
        if (ack_evt) begin
          bstate_nxt = SHBH_B_READY;
          srdy_nxt = bmode_s2_r;  // Falling edge signals ready in synchronous mode, rising edge in burst [RL8]
        end
      end
      SHBH_B_READY: begin
        if (bmode_s2_r) begin
          if (rdy_s_r) begin      // Host low holds beat in wait [RL3]
            bstate_nxt = SHBH_B_IDLE;
          end
        end else if (lat_write_r || !rdy_s_r) begin
          bstate_nxt = SHBH_B_IDLE;  // Read ends on ready return [RL1]
          srdy_nxt = 1'b1;
        end
      end
      default: begin
        bstate_nxt = SHBH_B_IDLE;
        srdy_nxt = 1'b1;
      end
    endcase
  end

  // State register
  always_ff @(posedge bus_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bstate_r <= SHBH_B_IDLE;
    end else begin
      bstate_r <= bstate_nxt;
    end
  end

  // Ready output, changed only on the bus clock
  always_ff @(posedge bus_clk_i or posedge rst_i) begin
    if (rst_i) begin
      srdy_r <= SHBH_SRDY_RST;
    end else begin
      srdy_r <= srdy_nxt;  // [RL9]
    end
  end

  assign sync_ready_n_o = srdy_r;

  // Direction and request toggle toward the core
  always_ff @(posedge bus_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_write_r <= 1'b0;
      req_tgl_r <= SHBH_TGL_RST;
    end else begin
      lat_write_r <= write_nxt;
      if (req_fire) begin
        req_tgl_r <= ~req_tgl_r;  // [RL7]
      end
    end
  end

  // ---------------------------------------------------------------
  // Core domain: request in, answer out
  // ---------------------------------------------------------------
  logic req_s1_r;
  logic req_s2_r;
  logic req_seen_r;
  logic req_evt;
  logic valid_r;
  logic [ADDR_W-1:0] addr_r;
  logic write_r;
  logic sel_r;

  // Request toggle synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_s1_r <= SHBH_TGL_RST;
      req_s2_r <= SHBH_TGL_RST;
      req_seen_r <= SHBH_TGL_RST;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_seen_r <= req_s2_r;
    end
  end

  assign req_evt = req_s2_r ^ req_seen_r;

  // Access held for the core until it answers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_r <= 1'b0;
      addr_r <= SHBH_ADDR_RST;
      write_r <= 1'b0;
      sel_r <= 1'b0;
      ack_tgl_r <= SHBH_TGL_RST;
    end else if (req_evt) begin
      valid_r <= 1'b1;
      addr_r <= lat_addr_r;   // Stable while bus side waits
      write_r <= lat_write_r;
      sel_r <= lat_sel_r;     // Queue data path selected [RL6]
    end else if (valid_r && acc_done_i) begin
      valid_r <= 1'b0;
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  assign acc_valid_o = valid_r;
  assign acc_addr_o = addr_r;
  assign acc_write_o = write_r;
  assign acc_data_sel_o = sel_r;

endmodule

`default_nettype wire

/* dv/shbh_chk.sv */
// Purpose: Port assertions for the host bus handshake
// Assumes: Strap steady while running
// Notes: Bound into every instance of the block
`default_nettype none
module shbh_chk
  import shbh_pkg::*;
#(
  parameter int ADDR_W = SHBH_ADDR_W,
  parameter logic [SHBH_DEC_W-1:0] BASE_HI = SHBH_BASE_RST
) (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_clk_i,
  // Host bus pins
  input wire logic address_strobe_n_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic address_qualifier_n_i,
  input wire logic data_path_select_n_i,
  input wire logic ready_return_n_i,
  input wire logic sync_ready_n_o,
  // Core side
  input wire logic acc_valid_o,
  input wire logic [ADDR_W-1:0] acc_addr_o,
  input wire logic acc_write_o,
  input wire logic acc_data_sel_o,
  input wire logic acc_done_i,
  input wire logic burst_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hit;
  logic srdy_neg_r;
  // Decode at a strobe rise
  assign hit = !data_path_select_n_i || (!address_qualifier_n_i && address_i[ADDR_W-1:SHBH_DEC_LSB] == BASE_HI);
  // Ready level seen mid bus cycle
  always_ff @(negedge bus_clk_i) srdy_neg_r <= sync_ready_n_o;
  a_ready_on_edge: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    sync_ready_n_o == srdy_neg_r) else $error("ready moved off edge");
  a_burst_wait_low: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    burst_mode_o && sync_ready_n_o && $rose(address_strobe_n_i) && hit |-> ##[1:2] !sync_ready_n_o)
    else $error("no burst wait");
  a_burst_wait_held: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    burst_mode_o && $fell(sync_ready_n_o) |=> !sync_ready_n_o [*4]) else $error("burst wait short");
  a_burst_ready_hold: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    burst_mode_o && $rose(sync_ready_n_o) |=> sync_ready_n_o [*2]) else $error("burst ready dropped");
  a_miss_ignored: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    !hit && sync_ready_n_o && $rose(address_strobe_n_i) |=> sync_ready_n_o [*3]) else $error("miss answered");
  a_sync_release: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    !burst_mode_o && !sync_ready_n_o && !ready_return_n_i |-> ##[1:2] sync_ready_n_o)
    else $error("ready not released");
  a_request_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_o && !acc_done_i |=> acc_valid_o && $stable(acc_addr_o) && $stable(acc_write_o)
    && $stable(acc_data_sel_o)) else $error("request moved");
  a_request_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_o && acc_done_i |=> !acc_valid_o) else $error("request stuck");
endmodule
bind shbh_sync_host_bus_handshake shbh_chk #(.ADDR_W(ADDR_W), .BASE_HI(BASE_HI)) chk (.clk_i, .rst_i, .bus_clk_i,
  .address_strobe_n_i, .address_i, .address_qualifier_n_i, .data_path_select_n_i, .ready_return_n_i,
  .sync_ready_n_o, .acc_valid_o, .acc_addr_o, .acc_write_o, .acc_data_sel_o, .acc_done_i, .burst_mode_o);
`default_nettype wire

/* dv/shbh_host_model.sv */
// Purpose: Host bus master model on the bus clock
// Assumes: Pull-ups on qualifier and select, pull-downs elsewhere
// Notes: One access per call; low_cnt and ok report the outcome
`default_nettype none
module shbh_host_model
  import shbh_pkg::*;
(
  // Bus clock and mode
  input wire logic bus_clk_i,
  input wire logic burst_i,
  // Host pins
  output logic strobe_n_o,
  output logic [SHBH_ADDR_W-1:0] addr_o,
  output logic qual_n_o,
  output logic dps_n_o,
  output logic cmd_n_o,
  output logic swr_o,
  output logic rr_n_o,
  input wire logic sync_ready_n_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int low_cnt;
  bit ok;
  // Released pins go to their pulls; address shows a stale inverse
  task automatic release_pins();
    addr_o = ~addr_o;
    qual_n_o = 1'b1;
    dps_n_o = 1'b1;
    strobe_n_o = 1'b0;
    cmd_n_o = 1'b0;
    swr_o = 1'b0;
    rr_n_o = (burst_i === 1'b1); // Burst host keeps it high, else pulled low
  endtask
  initial begin
    addr_o = '0;
    release_pins();
  end
  // One access; wait_c sets how long the host holds off
  task automatic access(input bit wr, input logic [SHBH_ADDR_W-1:0] a, input bit qn, input bit dn, input int wait_c);
    low_cnt = 0;
    ok = 1'b0;
    @(negedge bus_clk_i);
    strobe_n_o = 1'b0;
    addr_o = a;
    qual_n_o = qn;
    dps_n_o = dn;
    cmd_n_o = burst_i ? !wr : 1'b1;
    swr_o = wr;
    rr_n_o = 1'b1;
    @(negedge bus_clk_i);
    strobe_n_o = 1'b1;
    @(negedge bus_clk_i);
    if (!burst_i) cmd_n_o = 1'b0;
    for (int n = 0; n < 300 && !ok; n++) begin
      @(negedge bus_clk_i);
      if (sync_ready_n_i === 1'b0) low_cnt++;
      else if (low_cnt > 0) ok = 1'b1;
      if (low_cnt >= (burst_i ? 1 : wait_c)) rr_n_o = 1'b0;
    end
    repeat (burst_i ? wait_c : 0) @(negedge bus_clk_i);
    release_pins();
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for the host bus handshake
// Assumes: Core requests answered by the bench after core_wait cycles
// Notes: Bus clock 30 ns, offset from the 100 ns core clock
`default_nettype none
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); \
  end \
end
module tb
  import shbh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [SHBH_ADDR_W-1:0] HIT_A = {SHBH_BASE_RST, 3'h5};
  logic clk = 1'b0;
  logic bus_clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b0;
  logic done = 1'b0;
  logic strobe_n, qual_n, dps_n, cmd_n, sync_write_not_read, rr_n, srdy_n, valid, wr_o, sel_o, burst, got_wr, got_sel;
  logic [SHBH_ADDR_W-1:0] addr, acc_addr, got_addr;
  int bad_count = 0;
  int comparisons = 0;
  int reqs = 0;
  int core_wait = 0;
  int held = 0;
  // Clocks
  always #50 clk = ~clk;
  initial begin
    #7;
    forever #15 bus_clk = ~bus_clk; // 33 MHz, runs: no asynchronous mode used
  end
  shbh_sync_host_bus_handshake uut (.clk_i(clk), .rst_i(rst), .bus_clk_i(bus_clk), .bus_mode_strap_i(strap),
    .address_strobe_n_i(strobe_n), .address_i(addr), .address_qualifier_n_i(qual_n), .data_path_select_n_i(dps_n),
    .command_cycle_n_i(cmd_n), .sync_write_not_read_i(sync_write_not_read), .ready_return_n_i(rr_n), .sync_ready_n_o(srdy_n),
    .acc_valid_o(valid), .acc_addr_o(acc_addr), .acc_write_o(wr_o), .acc_data_sel_o(sel_o), .acc_done_i(done),
    .burst_mode_o(burst));
  shbh_host_model host (.bus_clk_i(bus_clk), .burst_i(strap), .strobe_n_o(strobe_n), .addr_o(addr), .qual_n_o(qual_n),
    .dps_n_o(dps_n), .cmd_n_o(cmd_n), .swr_o(sync_write_not_read), .rr_n_o(rr_n), .sync_ready_n_i(srdy_n));
  // Core side: answer each request after core_wait cycles, keep what it carried
  always @(negedge clk) begin
    if (valid === 1'b1 && done === 1'b0 && held < core_wait) begin
      held++;
    end else if (valid === 1'b1 && done === 1'b0) begin
      got_addr = acc_addr;
      got_wr = wr_o;
      got_sel = sel_o;
      reqs++;
      held = 0;
      done <= 1'b1;
    end else begin
      done <= 1'b0;
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("idle ready", 1'b1, srdy_n)
    `CHK("idle valid", 1'b0, valid)
    `CHK("mode", s, burst)
  endtask
  // One access through the host, then judge what the core saw
  task automatic xfer(input bit w, input logic [SHBH_ADDR_W-1:0] a, input bit qn, input bit dn, input int hold,
      input bit hit);
    int r0;
    r0 = reqs;
    host.access(w, a, qn, dn, hold);
    repeat (3) @(negedge clk);
    `CHK("completed", hit, host.ok)
    `CHK("requests", r0 + int'(hit), reqs)
    if (hit) begin
      `CHK("address", a, got_addr)
      `CHK("direction", w, got_wr)
      `CHK("data select", !dn, got_sel)
    end
  endtask
  task automatic t_sync_write();
    xfer(1'b1, HIT_A ^ 15'h0004, 1'b0, 1'b1, 0, 1'b1);
    `CHK("write ready", 1, host.low_cnt)
  endtask
  task automatic t_sync_read();
    core_wait = 2;
    xfer(1'b0, 15'h7fff, 1'b1, 1'b0, 3, 1'b1);
    core_wait = 0;
    `CHK("read ready held", 1'b1, host.low_cnt inside {[3:5]})
  endtask
  task automatic t_miss();
    xfer(1'b1, HIT_A, 1'b1, 1'b1, 0, 1'b0);
    xfer(1'b1, HIT_A ^ 15'h0008, 1'b0, 1'b1, 0, 1'b0);
    `CHK("miss ready", 0, host.low_cnt)
  endtask
  task automatic t_burst();
    do_reset(1'b1);
    xfer(1'b1, HIT_A, 1'b0, 1'b1, 3, 1'b1);
    `CHK("burst wait", 1'b1, host.low_cnt >= 4)
    xfer(1'b0, HIT_A, 1'b1, 1'b0, 2, 1'b1);
  endtask
  initial begin
    do_reset(1'b0);
    t_sync_write();
    t_sync_read();
    t_miss();
    t_burst();
    tally_and_finish();
  end
endmodule
`default_nettype wire
